//--- camera_link_pkg.sv
package camera_link_pkg;

  // Role codes on the two-bit configuration input; the other two codes are reserved.
  localparam logic [1:0] MODE_DESER       = 2'h0;
  localparam logic [1:0] MODE_SER         = 2'h1;

  localparam int         DATA_BITS        = 8;
  localparam int         WORD_BITS        = DATA_BITS + 2;

  localparam int         REF_CLK_MHZ      = 250;
  // Half period of the serial clock line; a longest time, so it rounds down.
  localparam int         SER_HALF_BIT_NS  = 8;
  localparam int         SER_HALF_BIT_CYC = (SER_HALF_BIT_NS * REF_CLK_MHZ / 1000 < 1) ? 1 :
                                            SER_HALF_BIT_NS * REF_CLK_MHZ / 1000;
  // Idle time of the serial clock between two words; a least time, so it rounds up.
  localparam int         WORD_GAP_NS      = 32;
  localparam int         WORD_GAP_CYC     = (WORD_GAP_NS * REF_CLK_MHZ + 999) / 1000;
  // Receiver restarts its bit count once the serial clock stays low this long.
  localparam int         RX_IDLE_CYC      = (WORD_GAP_CYC + 1) / 2;
  // Low phase of the regenerated pixel clock; a least time, so it rounds up.
  localparam int         PCLK_LOW_NS      = 16;
  localparam int         PCLK_LOW_CYC     = (PCLK_LOW_NS * REF_CLK_MHZ + 999) / 1000;

  localparam int         CNT_W            = 8;

  typedef struct packed {
    logic                 vsync;
    logic                 hsync;
    logic [DATA_BITS-1:0] data;
  } pixel_word_s;

  localparam pixel_word_s WORD_RESET      = '0;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_GAP} tx_state_e;

endpackage

//--- camera_link_serdes.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Mode 00 deserializer, 01 serializer, others reserved.
// [R2] Low power-down input keeps device asleep.
// [R3] Power-down idles data, clock, auxiliary serial lines.
// [R4] Serializer drives serial data; deserializer receives.
// [R5] Serializer drives serial clock; deserializer receives.
// [R6] Pixel bus output as deserializer, input otherwise.
// [R7] Sync pins output as deserializer, input otherwise.
// [R8] Pixel clock sampled, or regenerated as deserializer.
// [R9] Auxiliary parallel clock: deserializer input, serializer output.
// [R10] Auxiliary serial clock travels opposite to pixels.
// [R11] Ten bits per word: data plus syncs.
// [R12] Capture on pixel edge; regenerate pixel clock.
// [R13] Reserved mode leaves all two-way pins undriven.
module camera_link_serdes (
  input  wire logic                                  ref_clk,
  input  wire logic                                  rstn,
  input  wire logic                                  ce,
  input  wire logic [1:0]                            mode_cfg,
  input  wire logic                                  power_down_n,
  input  wire logic [camera_link_pkg::DATA_BITS-1:0] pixel_data_bus_in,
  output logic      [camera_link_pkg::DATA_BITS-1:0] pixel_data_bus_out,
  output logic                                       pixel_data_bus_oe,
  input  wire logic                                  vertical_sync_pin_in,
  output logic                                       vertical_sync_pin_out,
  output logic                                       vertical_sync_pin_oe,
  input  wire logic                                  horizontal_sync_pin_in,
  output logic                                       horizontal_sync_pin_out,
  output logic                                       horizontal_sync_pin_oe,
  input  wire logic                                  pixel_clock_pin_in,
  output logic                                       pixel_clock_pin_out,
  output logic                                       pixel_clock_pin_oe,
  input  wire logic                                  aux_parallel_clock_pin_in,
  output logic                                       aux_parallel_clock_pin_out,
  output logic                                       aux_parallel_clock_pin_oe,
  input  wire logic                                  serial_data_line_in,
  output logic                                       serial_data_line_out,
  output logic                                       serial_data_line_oe,
  input  wire logic                                  serial_clock_line_in,
  output logic                                       serial_clock_line_out,
  output logic                                       serial_clock_line_oe,
  input  wire logic                                  aux_serial_clock_line_in,
  output logic                                       aux_serial_clock_line_out,
  output logic                                       aux_serial_clock_line_oe
);

  localparam int SYNC_W = 18;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [SYNC_W-1:0]             meta_q;
  logic [SYNC_W-1:0]             sync_q;
  logic [SYNC_W-1:0]             raw_in;
  logic [1:0]                    mode_s;
  logic                          awake_s;
  camera_link_pkg::pixel_word_s  pix_s;
  logic                          pclk_s;
  logic                          auxp_s;
  logic                          sdata_s;
  logic                          sclk_s;
  logic                          auxs_s;
  logic                          pclk_d1_q;
  logic                          sclk_d1_q;
  logic                          role_ser;
  logic                          role_des;
  logic                          pclk_rise;
  logic                          sclk_rise;

  assign raw_in = {mode_cfg, power_down_n, vertical_sync_pin_in, horizontal_sync_pin_in, pixel_data_bus_in,
                   pixel_clock_pin_in, aux_parallel_clock_pin_in, serial_data_line_in, serial_clock_line_in,
                   aux_serial_clock_line_in};
  assign {mode_s, awake_s, pix_s, pclk_s, auxp_s, sdata_s, sclk_s, auxs_s} = sync_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q    <= '0;
      sync_q    <= '0;
      pclk_d1_q <= 1'b0;
      sclk_d1_q <= 1'b0;
    end else if (ce) begin
      meta_q    <= raw_in;
      sync_q    <= meta_q;
      pclk_d1_q <= pclk_s;
      sclk_d1_q <= sclk_s;
    end
  end

  // [R1] role decode
  assign role_ser  = (mode_s == camera_link_pkg::MODE_SER);
  assign role_des  = (mode_s == camera_link_pkg::MODE_DESER);
  assign pclk_rise = pclk_s & ~pclk_d1_q;
  assign sclk_rise = sclk_s & ~sclk_d1_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Serializer: word capture and shift-out.

  camera_link_pkg::pixel_word_s      pend_q;
  logic                              pend_valid_q;
  logic [camera_link_pkg::WORD_BITS-1:0] tx_shift_q;
  camera_link_pkg::tx_state_e        tx_state_q;
  logic [camera_link_pkg::CNT_W-1:0] tx_cnt_q;
  logic [3:0]                        tx_bit_q;
  logic                              tx_load;
  logic                              tx_run;

  assign tx_run  = role_ser & awake_s;
  assign tx_load = tx_run && (tx_state_q == camera_link_pkg::TX_IDLE) && pend_valid_q;

  // [R12] capture on pixel edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q       <= camera_link_pkg::WORD_RESET;
      pend_valid_q <= 1'b0;
    end else if (ce) begin
      if (tx_run && pclk_rise) begin
        pend_q       <= pix_s;
        pend_valid_q <= 1'b1;
      end else if (tx_load || !tx_run) begin
        pend_valid_q <= 1'b0;
      end
    end
  end

  // [R11] ten-bit word shifting
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_q            <= camera_link_pkg::TX_IDLE;
      tx_shift_q            <= '0;
      tx_cnt_q              <= '0;
      tx_bit_q              <= '0;
      serial_clock_line_out <= 1'b0;
      serial_data_line_out  <= 1'b0;
    end else if (ce) begin
      if (!tx_run) begin
        tx_state_q            <= camera_link_pkg::TX_IDLE;
        serial_clock_line_out <= 1'b0;
        serial_data_line_out  <= 1'b0;
      end else begin
        case (tx_state_q)
          camera_link_pkg::TX_IDLE: begin
            if (tx_load) begin
              tx_shift_q           <= pend_q;
              serial_data_line_out <= pend_q[0];
              tx_cnt_q             <= '0;
              tx_bit_q             <= '0;
              tx_state_q           <= camera_link_pkg::TX_SHIFT;
            end
          end
          camera_link_pkg::TX_SHIFT: begin
            if (tx_cnt_q == camera_link_pkg::CNT_W'(camera_link_pkg::SER_HALF_BIT_CYC - 1)) begin
              tx_cnt_q              <= '0;
              serial_clock_line_out <= ~serial_clock_line_out;
              if (serial_clock_line_out) begin
                if (tx_bit_q == 4'(camera_link_pkg::WORD_BITS - 1)) begin
                  tx_state_q <= camera_link_pkg::TX_GAP;
                end else begin
                  tx_bit_q             <= tx_bit_q + 4'h1;
                  serial_data_line_out <= tx_shift_q[tx_bit_q + 4'h1];
                end
              end
            end else begin
              tx_cnt_q <= tx_cnt_q + 1'b1;
            end
          end
          camera_link_pkg::TX_GAP: begin
            if (tx_cnt_q == camera_link_pkg::CNT_W'(camera_link_pkg::WORD_GAP_CYC - 1)) begin
              tx_cnt_q   <= '0;
              tx_state_q <= camera_link_pkg::TX_IDLE;
            end else begin
              tx_cnt_q <= tx_cnt_q + 1'b1;
            end
          end
          default: tx_state_q <= camera_link_pkg::TX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Deserializer: word assembly and pixel clock regeneration.

  logic [camera_link_pkg::WORD_BITS-1:0] rx_shift_q;
  logic [3:0]                        rx_bit_q;
  logic [camera_link_pkg::CNT_W-1:0] rx_idle_q;
  logic [camera_link_pkg::CNT_W-1:0] pclk_cnt_q;
  logic                              rx_run;
  logic                              rx_done;
  camera_link_pkg::pixel_word_s      rx_word;

  assign rx_run  = role_des & awake_s;
  assign rx_done = rx_run && sclk_rise && (rx_bit_q == 4'(camera_link_pkg::WORD_BITS - 1));
  assign rx_word = {sdata_s, rx_shift_q[camera_link_pkg::WORD_BITS-2:0]};

  // Bit count restarts after an idle gap so a lost edge costs at most one word.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_shift_q <= '0;
      rx_bit_q   <= '0;
      rx_idle_q  <= '0;
    end else if (ce) begin
      if (!rx_run) begin
        rx_bit_q  <= '0;
        rx_idle_q <= '0;
      end else if (sclk_rise) begin
        rx_idle_q            <= '0;
        rx_shift_q[rx_bit_q] <= sdata_s;
        rx_bit_q             <= rx_done ? 4'h0 : rx_bit_q + 4'h1;
      end else if (!sclk_s) begin
        if (rx_idle_q == camera_link_pkg::CNT_W'(camera_link_pkg::RX_IDLE_CYC)) begin
          rx_bit_q <= '0;
        end else begin
          rx_idle_q <= rx_idle_q + 1'b1;
        end
      end
    end
  end

  // [R12] regenerated pixel clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pixel_data_bus_out      <= '0;
      vertical_sync_pin_out   <= 1'b0;
      horizontal_sync_pin_out <= 1'b0;
      pixel_clock_pin_out     <= 1'b0;
      pclk_cnt_q              <= '0;
    end else if (ce) begin
      if (rx_done) begin
        // [R11] restore all ten bits
        pixel_data_bus_out      <= rx_word.data;
        vertical_sync_pin_out   <= rx_word.vsync;
        horizontal_sync_pin_out <= rx_word.hsync;
        pixel_clock_pin_out     <= 1'b0;
        pclk_cnt_q              <= '0;
      end else if (!pixel_clock_pin_out) begin
        if (pclk_cnt_q == camera_link_pkg::CNT_W'(camera_link_pkg::PCLK_LOW_CYC - 1)) begin
          pixel_clock_pin_out <= 1'b1;
        end else begin
          pclk_cnt_q <= pclk_cnt_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin direction and auxiliary clock transport.

  // [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R13] direction control
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pixel_data_bus_oe          <= 1'b0;
      vertical_sync_pin_oe       <= 1'b0;
      horizontal_sync_pin_oe     <= 1'b0;
      pixel_clock_pin_oe         <= 1'b0;
      aux_parallel_clock_pin_oe  <= 1'b0;
      serial_data_line_oe        <= 1'b0;
      serial_clock_line_oe       <= 1'b0;
      aux_serial_clock_line_oe   <= 1'b0;
      aux_parallel_clock_pin_out <= 1'b0;
      aux_serial_clock_line_out  <= 1'b0;
    end else if (ce) begin
      pixel_data_bus_oe          <= role_des;
      vertical_sync_pin_oe       <= role_des;
      horizontal_sync_pin_oe     <= role_des;
      pixel_clock_pin_oe         <= role_des;
      aux_parallel_clock_pin_oe  <= role_ser;
      serial_data_line_oe        <= tx_run;
      serial_clock_line_oe       <= tx_run;
      aux_serial_clock_line_oe   <= rx_run;
      aux_parallel_clock_pin_out <= role_ser & auxs_s;
      aux_serial_clock_line_out  <= rx_run & auxp_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_sleep_holds_tx: assert property (ce && !awake_s |=> tx_state_q == camera_link_pkg::TX_IDLE && !pend_valid_q) // [R2]
    else $error("Transmitter active while asleep.");
  a_pd_lines_idle: assert property (ce && !awake_s |=> !serial_data_line_oe && !serial_clock_line_oe && // [R3]
                                    !aux_serial_clock_line_oe)
    else $error("Serial line driven during power-down.");
  a_ser_data_drive: assert property (ce |=> serial_data_line_oe == $past(tx_run)) // [R4]
    else $error("Serial data drive does not follow role.");
  a_ser_clock_drive: assert property (ce && role_des |=> !serial_clock_line_oe) // [R5]
    else $error("Deserializer drives serial clock.");
  a_bus_direction: assert property (ce |=> pixel_data_bus_oe == $past(role_des)) // [R6]
    else $error("Pixel bus direction wrong.");
  a_sync_direction: assert property (ce |=> vertical_sync_pin_oe == pixel_data_bus_oe && // [R7]
                                     horizontal_sync_pin_oe == pixel_data_bus_oe)
    else $error("Sync pin direction wrong.");
  a_pclk_regen: assert property (ce && rx_done |=> !pixel_clock_pin_out ##1 (!pixel_clock_pin_out || !ce)) // [R8]
    else $error("Regenerated pixel clock not low after a word.");
  a_aux_par_drive: assert property (ce |=> aux_parallel_clock_pin_oe == $past(role_ser)) // [R9]
    else $error("Auxiliary parallel clock direction wrong.");
  a_aux_opposite: assert property (ce |=> !(aux_serial_clock_line_oe && aux_parallel_clock_pin_oe)) // [R10]
    else $error("Both auxiliary clock pins driven.");
  a_word_restore: assert property (ce && rx_done |=> {vertical_sync_pin_out, horizontal_sync_pin_out, // [R11]
                                   pixel_data_bus_out} == $past(rx_word))
    else $error("Received word not restored.");
  a_capture_load: assert property (ce && tx_run && pclk_rise |=> pend_valid_q && pend_q == $past(pix_s)) // [R12]
    else $error("Pixel word not captured.");
  a_reserved_float: assert property (ce && !role_ser && !role_des |=> !pixel_data_bus_oe && // [R13]
                                     !serial_data_line_oe && !serial_clock_line_oe && !pixel_clock_pin_oe)
    else $error("Pin driven in reserved mode.");

  c_tx_word: cover property (tx_state_q == camera_link_pkg::TX_SHIFT ##[1:200] tx_state_q == camera_link_pkg::TX_GAP);
  c_rx_word: cover property (rx_done);
  c_power_down: cover property (awake_s ##1 !awake_s);
  c_reserved: cover property (!role_ser && !role_des && awake_s);

endmodule // camera_link_serdes

//--- camera_link_partner.sv
`timescale 1ns/1ps
module camera_link_partner (
  input  wire logic ref_clk,
  input  wire logic tx_role,
  input  wire logic aux_src,
  input  wire logic dev_data_out,
  input  wire logic dev_data_oe,
  input  wire logic dev_clk_out,
  input  wire logic dev_clk_oe,
  input  wire logic dev_aux_out,
  input  wire logic dev_aux_oe,
  output logic      data_wire,
  output logic      clk_wire,
  output logic      aux_wire
);
  logic own_data_q  = 1'b0;
  logic own_clk_q   = 1'b0;
  logic own_busy_q  = 1'b0;
  logic last_data_q = 1'b0;
  logic last_clk_q  = 1'b0;

  // A released line shows the inverse of its last level, so a stale value is never read as good.
  always @(posedge ref_clk) begin
    last_data_q <= data_wire;
    last_clk_q  <= clk_wire;
  end

  assign data_wire = dev_data_oe ? dev_data_out : (tx_role && own_busy_q) ? own_data_q : ~last_data_q;
  assign clk_wire  = dev_clk_oe ? dev_clk_out : tx_role ? own_clk_q : ~last_clk_q;
  assign aux_wire  = dev_aux_oe ? dev_aux_out : aux_src;

  ////////////////////////////////////////
  // ten bits framed
  task automatic send_word(input camera_link_pkg::pixel_word_s w, input int half);
    logic [9:0] b;
    b = w;
    own_busy_q <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      own_data_q <= b[i];
      own_clk_q  <= 1'b0;
      repeat (half) @(posedge ref_clk);
      own_clk_q <= 1'b1;
      repeat (half) @(posedge ref_clk);
    end
    own_clk_q <= 1'b0;
    repeat (2) @(posedge ref_clk);
    own_busy_q <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic recv_word(output camera_link_pkg::pixel_word_s w, output bit ok);
    logic [9:0] b;
    logic       prev;
    int         n;
    ok = 1'b1;
    for (int i = 0; i < 10; i++) begin
      n = 0;
      do begin
        prev = clk_wire;
        @(negedge ref_clk);
        n++;
      end while (!(clk_wire && !prev) && n < 200);
      if (n >= 200) ok = 1'b0;
      b[i] = data_wire;
    end
    w = b;
  endtask
endmodule // camera_link_partner

//--- tb_camera_link_serdes.sv
`timescale 1ns/1ps
module tb_camera_link_serdes;
  logic       ref_clk, rstn, ce, power_down_n, tx_role, aux_src, vs_d, hs_d, pclk_d;
  logic [1:0] mode_cfg;
  logic [7:0] pix_d, pixel_data_bus_in, pixel_data_bus_out;
  logic       pixel_data_bus_oe, vertical_sync_pin_in, vertical_sync_pin_out, vertical_sync_pin_oe;
  logic       horizontal_sync_pin_in, horizontal_sync_pin_out, horizontal_sync_pin_oe;
  logic       pixel_clock_pin_in, pixel_clock_pin_out, pixel_clock_pin_oe;
  logic       aux_parallel_clock_pin_in, aux_parallel_clock_pin_out, aux_parallel_clock_pin_oe;
  logic       serial_data_line_in, serial_data_line_out, serial_data_line_oe;
  logic       serial_clock_line_in, serial_clock_line_out, serial_clock_line_oe;
  logic       aux_serial_clock_line_in, aux_serial_clock_line_out, aux_serial_clock_line_oe;
  int         failures, n_compared;
  logic [9:0] words [4] = '{10'h2A5, 10'h15A, 10'h3FF, 10'h000};
  wire  [7:0] oe_v = {pixel_data_bus_oe, vertical_sync_pin_oe, horizontal_sync_pin_oe, pixel_clock_pin_oe,
                      aux_parallel_clock_pin_oe, serial_data_line_oe, serial_clock_line_oe, aux_serial_clock_line_oe};

  assign pixel_data_bus_in         = pixel_data_bus_oe ? pixel_data_bus_out : pix_d;
  assign vertical_sync_pin_in      = vertical_sync_pin_oe ? vertical_sync_pin_out : vs_d;
  assign horizontal_sync_pin_in    = horizontal_sync_pin_oe ? horizontal_sync_pin_out : hs_d;
  assign pixel_clock_pin_in        = pixel_clock_pin_oe ? pixel_clock_pin_out : pclk_d;
  assign aux_parallel_clock_pin_in = aux_parallel_clock_pin_oe ? aux_parallel_clock_pin_out : aux_src;

  camera_link_serdes u_dut (.ref_clk, .rstn, .ce, .mode_cfg, .power_down_n, .pixel_data_bus_in,
    .pixel_data_bus_out, .pixel_data_bus_oe, .vertical_sync_pin_in, .vertical_sync_pin_out,
    .vertical_sync_pin_oe, .horizontal_sync_pin_in, .horizontal_sync_pin_out, .horizontal_sync_pin_oe,
    .pixel_clock_pin_in, .pixel_clock_pin_out, .pixel_clock_pin_oe, .aux_parallel_clock_pin_in,
    .aux_parallel_clock_pin_out, .aux_parallel_clock_pin_oe, .serial_data_line_in, .serial_data_line_out,
    .serial_data_line_oe, .serial_clock_line_in, .serial_clock_line_out, .serial_clock_line_oe,
    .aux_serial_clock_line_in, .aux_serial_clock_line_out, .aux_serial_clock_line_oe);

  camera_link_partner u_partner (.ref_clk, .tx_role, .aux_src, .dev_data_out(serial_data_line_out),
    .dev_data_oe(serial_data_line_oe), .dev_clk_out(serial_clock_line_out), .dev_clk_oe(serial_clock_line_oe),
    .dev_aux_out(aux_serial_clock_line_out), .dev_aux_oe(aux_serial_clock_line_oe),
    .data_wire(serial_data_line_in), .clk_wire(serial_clock_line_in), .aux_wire(aux_serial_clock_line_in));

  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // The extra clock source runs with an 80 ns period.
  always begin
    repeat (10) @(posedge ref_clk);
    aux_src <= ~aux_src;
  end

  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input camera_link_pkg::pixel_word_s got, input camera_link_pkg::pixel_word_s exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic lost();
    failures++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  endtask

  task automatic set_mode(input logic [1:0] m, input logic pd);
    @(posedge ref_clk);
    mode_cfg     <= m;
    power_down_n <= pd;
    tx_role      <= (m == camera_link_pkg::MODE_DESER);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic chk_aux(input bit ser);
    int   st;
    logic p;
    st = 0;
    p  = aux_src;
    for (int k = 0; k < 60; k++) begin
      @(negedge ref_clk);
      st = (aux_src === p) ? st + 1 : 0;
      p  = aux_src;
      if (st == 6) chk_bits({7'h00, ser ? aux_parallel_clock_pin_out : aux_serial_clock_line_out}, {7'h00, p});
    end
  endtask

  ////////////////////////////////////////
  task automatic test_ser();
    camera_link_pkg::pixel_word_s got;
    bit                           ok;
    set_mode(camera_link_pkg::MODE_SER, 1'b1);
    chk_bits(oe_v, 8'h0E);
    for (int i = 0; i < 4; i++) begin
      fork
        u_partner.recv_word(got, ok);
        begin
          @(posedge ref_clk);
          {vs_d, hs_d, pix_d} <= words[i];
          pclk_d              <= 1'b0;
          repeat (6) @(posedge ref_clk);
          pclk_d <= 1'b1;
          repeat (30) @(posedge ref_clk);
        end
      join
      if (!ok) lost();
      chk_word(got, words[i]);
    end
    chk_aux(1'b1);
    $display("test serializer done");
  endtask

  task automatic test_des();
    logic prev;
    int   n;
    set_mode(camera_link_pkg::MODE_DESER, 1'b1);
    chk_bits(oe_v, 8'hF1);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      n = 0;
      fork
        u_partner.send_word(words[i], 2 + i % 2);
        do begin
          prev = pixel_clock_pin_out;
          @(negedge ref_clk);
          n++;
        end while (!(pixel_clock_pin_out && !prev) && n < 300);
      join
      if (n >= 300) lost();
      chk_word({vertical_sync_pin_out, horizontal_sync_pin_out, pixel_data_bus_out}, words[i]);
    end
    chk_aux(1'b0);
    $display("test deserializer done");
  endtask

  task automatic test_sleep();
    for (int i = 0; i < 2; i++) begin
      set_mode(i ? camera_link_pkg::MODE_SER : camera_link_pkg::MODE_DESER, 1'b0);
      chk_bits(oe_v, i ? 8'h08 : 8'hF0);
      chk_bits({5'h00, serial_data_line_out, serial_clock_line_out, aux_serial_clock_line_out}, 8'h00);
    end
    $display("test power down done");
  endtask

  task automatic test_reserved();
    for (int m = 2; m < 4; m++) begin
      set_mode(m[1:0], 1'b1);
      chk_bits(oe_v, 8'h00);
    end
    $display("test reserved done");
  endtask

  initial begin
    rstn         = 1'b0;
    ce           = 1'b1;
    mode_cfg     = 2'h0;
    power_down_n = 1'b0;
    tx_role      = 1'b0;
    aux_src      = 1'b0;
    pix_d        = 8'h00;
    vs_d         = 1'b0;
    hs_d         = 1'b0;
    pclk_d       = 1'b0;
    failures     = 0;
    n_compared   = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    test_ser();
    test_des();
    test_sleep();
    test_reserved();
    stop_test();
  end
endmodule // tb_camera_link_serdes
